// ===== core/wwd_top.sv
// Purpose: Window watchdog core with pin probe and AXI4-Lite status
// Assumes: supply_ok is the undervoltage monitor level, high when supply is good
// Notes:   Analog pins are modelled as levels, pulldown and charge enables
//
// Overview of operation
// - Probe reset delay pin after supply rises
// - Probe window timeout pin after supply rises
// - Factory or capacitor hold time from probe
// - Four select modes including disabled
// - Disabled: output high, kicks ignored
// - Enable or disable acts at once
// - Ratio latched only on power-up, fault entry or enable
// - Kicks ignored during settle after enable
// - Factory hold: re-enable behaves as normal enable
// - Capacitor hold: disable releases, re-enable waits hold
// - Only falling kick edges count
// - First kick has only an upper limit
// - Later kicks must fall inside the window
// - Fault holds low and ignores kicks
// - Ratio encoding for capacitor timing
// - Factory hold 200 ms open, 10 ms pulled up
// - Stay disabled for one hold after power-up
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module wwd_top #(
  parameter int TICK_CYC   = wwd_pkg::TICK_CYC_DEF,
  parameter int PROBE_US   = wwd_pkg::PROBE_US_DEF,
  parameter int SETTLE_US  = wwd_pkg::SETTLE_US_DEF,
  parameter int TIME_SHIFT = 0
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Supply monitor
  input  wire logic                   supply_ok,
  // Watchdog pins
  input  wire logic                   window_select_0,
  input  wire logic                   window_select_1,
  input  wire logic                   kick_input,
  output logic                        fault_output_n,
  // Configuration pins
  input  wire logic                   reset_delay_cfg_pin,
  input  wire logic                   window_timeout_cfg_pin,
  output logic                        rst_cfg_pulldown,
  output logic                        wd_cfg_pulldown,
  // Capacitor comparators and charge sources
  input  wire logic                   rst_cap_done,
  input  wire logic                   wd_cap_done,
  output logic                        rst_cap_charge,
  output logic                        wd_cap_charge,
  // AXI4-Lite write
  input  wire logic [wwd_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [wwd_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  import wwd_pkg::*;

  localparam int NS = 8;
  localparam int I_S0 = 0;
  localparam int I_S1 = 1;
  localparam int I_KICK = 2;
  localparam int I_SUP = 3;
  localparam int I_RLV = 4;
  localparam int I_WLV = 5;
  localparam int I_RDN = 6;
  localparam int I_WDN = 7;
  localparam logic [15:0]   TICK_LAST  = 16'(TICK_CYC - 1);
  localparam logic [TW-1:0] PROBE_LAST = TW'(PROBE_US - 1);
  localparam logic [TW-1:0] PROBE_HALF = TW'(PROBE_US / 2);
  localparam logic [TW-1:0] SETTLE_T   = TW'(SETTLE_US);

  logic [NS-1:0]    pins_s;
  logic [15:0]      ps_r;
  logic [TW-1:0]    cnt_r;
  logic [TW-1:0]    cap_ticks_r;
  logic [TW-1:0]    upper_t;
  logic [TW-1:0]    lower_t;
  logic [TW-1:0]    hold_t;
  logic [1:0]       sel;
  logic [1:0]       ratio_r;
  logic [1:0]       pu_r;
  logic [CNT_W-1:0] faults_r;
  wwd_cfg_e         rcfg_r;
  wwd_cfg_e         wcfg_r;
  wwd_state_e       st_r;
  wwd_state_e       st_nxt;
  logic             tick;
  logic             kick_prev_r;
  logic             kick_fall;
  logic             sel_dis;
  logic             sup;
  logic             probe_mid;
  logic             probe_end;
  logic             hold_done;
  logic             timeout;
  logic             early;
  logic             restart;
  logic             fault_in;
  logic             pend_r;
  logic             watching;
  logic             cnt_clr;

  // All pins pass the same filter, one instance for the lot
  wwd_sync #(.W(NS)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({wd_cap_done, rst_cap_done, window_timeout_cfg_pin, reset_delay_cfg_pin,
               supply_ok, kick_input, window_select_1, window_select_0}),
    .q       (pins_s)
  );

  assign sel       = {pins_s[I_S1], pins_s[I_S0]};
  assign sel_dis   = sel == SEL_DIS;
  assign sup       = pins_s[I_SUP];
  assign kick_fall = kick_prev_r && !pins_s[I_KICK];
  assign tick      = ps_r == TICK_LAST;
  assign probe_mid = st_r == ST_PROBE && tick && cnt_r == PROBE_HALF;
  assign probe_end = st_r == ST_PROBE && tick && cnt_r == PROBE_LAST;
  assign watching  = st_r == ST_FIRST || st_r == ST_WINDOW;

  function automatic logic [TW-1:0] frac_f(input logic [TW-1:0] x, input logic [1:0] r);
    case (r)
      SEL_R18: frac_f = x >> SH_EIGHTH;
      SEL_R12: frac_f = x >> SH_HALF;
      SEL_R34: frac_f = x - (x >> SH_QUARTER);
      default: frac_f = '0;
    endcase
  endfunction

  function automatic logic [TW-1:0] fac_f(input logic up, input logic pu, input logic [1:0] r);
    case ({up, pu, r})
      {1'b1, 1'b0, SEL_R18}: fac_f = UP_OPEN_R18;
      {1'b1, 1'b0, SEL_R34}: fac_f = UP_OPEN_R34;
      {1'b1, 1'b0, SEL_R12}: fac_f = UP_OPEN_R12;
      {1'b1, 1'b1, SEL_R18}: fac_f = UP_PU_R18;
      {1'b1, 1'b1, SEL_R34}: fac_f = UP_PU_R34;
      {1'b1, 1'b1, SEL_R12}: fac_f = UP_PU_R12;
      {1'b0, 1'b0, SEL_R18}: fac_f = LO_OPEN_R18;
      {1'b0, 1'b0, SEL_R34}: fac_f = LO_OPEN_R34;
      {1'b0, 1'b0, SEL_R12}: fac_f = LO_OPEN_R12;
      {1'b0, 1'b1, SEL_R18}: fac_f = LO_PU_R18;
      {1'b0, 1'b1, SEL_R34}: fac_f = LO_PU_R34;
      {1'b0, 1'b1, SEL_R12}: fac_f = LO_PU_R12;
      default:               fac_f = '0;
    endcase
  endfunction

  // Tick counts from microsecond parameters, scaled down for simulation
  assign upper_t = fac_f(1'b1, wcfg_r == CFG_PULLUP, ratio_r) >> TIME_SHIFT;
  assign lower_t = (wcfg_r == CFG_CAP) ? frac_f(cap_ticks_r, ratio_r)
                 : fac_f(1'b0, wcfg_r == CFG_PULLUP, ratio_r) >> TIME_SHIFT;
  assign hold_t  = ((rcfg_r == CFG_PULLUP) ? HOLD_PU_US : HOLD_OPEN_US) >> TIME_SHIFT;

  // Capacitor comparators replace the counters when fitted
  assign hold_done = (rcfg_r == CFG_CAP) ? pins_s[I_RDN] : cnt_r >= hold_t;
  assign timeout   = (wcfg_r == CFG_CAP) ? pins_s[I_WDN] : cnt_r >= upper_t;
  assign early     = cnt_r < lower_t;

  always_comb
  begin
    st_nxt  = st_r;
    restart = 1'b0;
    if (!sup)
      st_nxt = ST_UVLO;
    else
    begin
      case (st_r)
        ST_UVLO:    st_nxt = ST_PROBE;
        ST_PROBE:   if (probe_end) st_nxt = ST_BOOT;
        ST_BOOT:    if (hold_done) st_nxt = sel_dis ? ST_DIS : ST_FIRST;
        ST_DIS:     if (!sel_dis) st_nxt = pend_r ? ST_RECOVER : ST_SETTLE;
        ST_SETTLE:
        begin
          if (sel_dis)
            st_nxt = ST_DIS;
          else if (cnt_r >= SETTLE_T)
            st_nxt = ST_FIRST;
        end
        ST_RECOVER:
        begin
          if (sel_dis)
            st_nxt = ST_DIS;
          else if (hold_done)
            st_nxt = ST_FIRST;
        end
        ST_FIRST:
        begin
          if (sel_dis)
            st_nxt = ST_DIS;
          else if (timeout)
            st_nxt = ST_FAULT;
          else if (kick_fall)
            st_nxt = ST_WINDOW;
        end
        ST_WINDOW:
        begin
          if (sel_dis)
            st_nxt = ST_DIS;
          else if (timeout || (kick_fall && early))
            st_nxt = ST_FAULT;
          else if (kick_fall)
            restart = 1'b1;
        end
        ST_FAULT:
        begin
          if (sel_dis)
            st_nxt = ST_DIS;
          else if (hold_done)
            st_nxt = ST_FIRST;
        end
        default:    st_nxt = ST_UVLO;
      endcase
    end
  end

  assign fault_in = st_nxt == ST_FAULT && st_r != ST_FAULT;
  assign cnt_clr  = st_nxt != st_r || restart;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r        <= ST_UVLO;
      ps_r        <= '0;
      cnt_r       <= '0;
      kick_prev_r <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      ps_r        <= (tick || cnt_clr) ? '0 : ps_r + 16'h0001;
      cnt_r       <= cnt_clr ? '0 : cnt_r + TW'(tick);
      kick_prev_r <= pins_s[I_KICK];
    end
  end

  // Probe: pulldown first half, charge source second half
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pu_r   <= '0;
      rcfg_r <= CFG_OPEN;
      wcfg_r <= CFG_OPEN;
    end
    else
    begin
      if (probe_mid)
        pu_r <= {pins_s[I_WLV], pins_s[I_RLV]};
      if (probe_end)
      begin
        rcfg_r <= pu_r[0] ? CFG_PULLUP : (pins_s[I_RLV] ? CFG_OPEN : CFG_CAP);
        wcfg_r <= pu_r[1] ? CFG_PULLUP : (pins_s[I_WLV] ? CFG_OPEN : CFG_CAP);
      end
    end
  end

  // Ratio only moves on power-up, fault entry or enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ratio_r     <= SEL_R18;
      pend_r      <= 1'b0;
      cap_ticks_r <= '0;
    end
    else
    begin
      if (probe_end || fault_in || (st_r == ST_DIS && !sel_dis))
        ratio_r <= sel;
      if (!sup || (st_r == ST_RECOVER && st_nxt == ST_FIRST))
        pend_r <= 1'b0;
      else if (st_r == ST_FAULT && sel_dis && rcfg_r == CFG_CAP)
        pend_r <= 1'b1;
      if (wcfg_r == CFG_CAP && watching && pins_s[I_WDN])
        cap_ticks_r <= cnt_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_output_n   <= 1'b1;
      rst_cfg_pulldown <= 1'b0;
      wd_cfg_pulldown  <= 1'b0;
      rst_cap_charge   <= 1'b0;
      wd_cap_charge    <= 1'b0;
    end
    else
    begin
      fault_output_n   <= st_nxt != ST_FAULT;
      rst_cfg_pulldown <= st_nxt == ST_PROBE && cnt_r < PROBE_HALF;
      wd_cfg_pulldown  <= st_nxt == ST_PROBE && cnt_r < PROBE_HALF;
      rst_cap_charge   <= (st_nxt == ST_PROBE && cnt_r >= PROBE_HALF) || (rcfg_r == CFG_CAP
                          && (st_nxt == ST_BOOT || st_nxt == ST_FAULT || st_nxt == ST_RECOVER));
      // Short discharge on each accepted kick restarts the capacitor window
      wd_cap_charge    <= (st_nxt == ST_PROBE && cnt_r >= PROBE_HALF) || (wcfg_r == CFG_CAP
                          && (st_nxt == ST_FIRST || st_nxt == ST_WINDOW) && !restart && !cnt_clr);
    end
  end

  // AXI4-Lite slave: one write and one read in flight
  logic             aw_full_r;
  logic             w_full_r;
  logic [AW-1:0]    awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             do_wr;
  logic             aw_full_nxt;
  logic             w_full_nxt;
  logic             bvalid_nxt;
  logic             rvalid_nxt;
  logic             ar_hs;
  logic             clr_req;
  logic [31:0]      rd_word;
  logic [1:0]       rd_resp;

  assign do_wr       = aw_full_r && w_full_r && !s_axi_bvalid;
  assign aw_full_nxt = (s_axi_awvalid && s_axi_awready) || (aw_full_r && !do_wr);
  assign w_full_nxt  = (s_axi_wvalid && s_axi_wready) || (w_full_r && !do_wr);
  assign bvalid_nxt  = do_wr || (s_axi_bvalid && !s_axi_bready);
  assign ar_hs       = s_axi_arvalid && s_axi_arready;
  assign rvalid_nxt  = ar_hs || (s_axi_rvalid && !s_axi_rready);
  assign clr_req     = do_wr && awaddr_r == OFS_CTRL && wstrb_r[0] && wdata_r[CTRL_CLR_BIT];

  always_comb
  begin
    rd_word = '0;
    rd_resp = RESP_OKAY;
    if (s_axi_araddr == OFS_STATUS)
      rd_word = {{STAT_PAD{1'b0}}, fault_output_n, ratio_r, wcfg_r, rcfg_r, st_r};
    else if (s_axi_araddr == OFS_FAULTS)
      rd_word = {{(32 - CNT_W){1'b0}}, faults_r};
    else if (s_axi_araddr != OFS_CTRL)
      rd_resp = RESP_SLVERR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      aw_full_r     <= aw_full_nxt;
      w_full_r      <= w_full_nxt;
      s_axi_awready <= !aw_full_nxt && !bvalid_nxt;
      s_axi_wready  <= !w_full_nxt && !bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (s_axi_awvalid && s_axi_awready)
        awaddr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr)
        s_axi_bresp <= (awaddr_r == OFS_STATUS || awaddr_r == OFS_FAULTS || awaddr_r == OFS_CTRL)
                       ? RESP_OKAY : RESP_SLVERR;
      if (ar_hs)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_resp;
      end
    end
  end

  // A fault in the clearing cycle still counts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      faults_r <= '0;
    else if (fault_in)
      faults_r <= clr_req ? CNT_W'(1) : faults_r + CNT_W'(1);
    else if (clr_req)
      faults_r <= '0;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_probe_to_boot: assert property (probe_end && sup |=> st_r == ST_BOOT)
    else $error("probe did not end in boot hold");
  a_dis_output_high: assert property (st_r == ST_DIS |-> fault_output_n && !(st_nxt == ST_FAULT))
    else $error("fault output low while disabled");
  a_dis_immediate: assert property (watching && sup && sel_dis |=> st_r == ST_DIS)
    else $error("disable not taken at once");
  a_ratio_hold: assert property (st_r == ST_WINDOW && $past(st_r) == ST_WINDOW |-> $stable(ratio_r))
    else $error("ratio changed during monitoring");
  a_settle_entry: assert property (st_r == ST_DIS && sup && !sel_dis && !pend_r |=> st_r == ST_SETTLE)
    else $error("enable skipped settle period");
  a_settle_ignore: assert property (st_r == ST_SETTLE && sup && !sel_dis |=> st_r != ST_FAULT && st_r != ST_WINDOW)
    else $error("kick acted during settle");
  a_cap_release: assert property (st_r == ST_FAULT && sup && sel_dis && rcfg_r == CFG_CAP
    |=> fault_output_n && pend_r && st_r == ST_DIS)
    else $error("capacitor fault not released on disable");
  a_first_no_early: assert property (st_r == ST_FIRST && sup && !sel_dis && !timeout && kick_fall
    |=> st_r == ST_WINDOW && fault_output_n && cnt_r == '0)
    else $error("first kick treated as early");
  a_early_fault: assert property (st_r == ST_WINDOW && sup && !sel_dis && kick_fall && early
    |=> !fault_output_n)
    else $error("early kick did not fault");
  a_fault_only: assert property (!fault_output_n |-> st_r == ST_FAULT)
    else $error("fault output low outside fault");
  a_hold_length: assert property (st_r == ST_FAULT && rcfg_r != CFG_CAP |-> cnt_r <= hold_t)
    else $error("factory hold overran");
  a_boot_hold: assert property (st_r == ST_BOOT && rcfg_r != CFG_CAP |-> fault_output_n && cnt_r <= hold_t)
    else $error("boot hold overran or output low");

endmodule

// ===== core/wwd_pkg.sv
// Purpose: Shared constants and types for the window watchdog
// Assumes: 100 MHz aclk, timing counted in 1 us ticks
// Notes:   Times are in microseconds as printed; tick counts are derived
package wwd_pkg;

  // Clock and timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC_DEF  = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TW            = 22;

  // Sequence times in microseconds
  localparam int PROBE_US_DEF  = 381;
  localparam int SETTLE_US_DEF = 150;

  // Factory hold times in microseconds
  localparam logic [TW-1:0] HOLD_OPEN_US = 22'd200000;
  localparam logic [TW-1:0] HOLD_PU_US   = 22'd10000;

  // Factory window bounds in microseconds, open pin
  localparam logic [TW-1:0] UP_OPEN_R18 = 22'd55000;
  localparam logic [TW-1:0] UP_OPEN_R34 = 22'd27500;
  localparam logic [TW-1:0] UP_OPEN_R12 = 22'd1600000;
  localparam logic [TW-1:0] LO_OPEN_R18 = 22'd22500;
  localparam logic [TW-1:0] LO_OPEN_R34 = 22'd1850;
  localparam logic [TW-1:0] LO_OPEN_R12 = 22'd800000;

  // Factory window bounds in microseconds, pulled-up pin
  localparam logic [TW-1:0] UP_PU_R18 = 22'd109000;
  localparam logic [TW-1:0] UP_PU_R34 = 22'd195000;
  localparam logic [TW-1:0] UP_PU_R12 = 22'd11000;
  localparam logic [TW-1:0] LO_PU_R18 = 22'd9000;
  localparam logic [TW-1:0] LO_PU_R34 = 22'd9000;
  localparam logic [TW-1:0] LO_PU_R12 = 22'd1850;

  // Select pair {window_select_1, window_select_0}
  localparam logic [1:0] SEL_R18 = 2'h0;
  localparam logic [1:0] SEL_DIS = 2'h1;
  localparam logic [1:0] SEL_R34 = 2'h2;
  localparam logic [1:0] SEL_R12 = 2'h3;

  // Ratio shifts for capacitor timing
  localparam int SH_EIGHTH  = 3;
  localparam int SH_QUARTER = 2;
  localparam int SH_HALF    = 1;

  typedef enum logic [1:0] {
    CFG_OPEN   = 2'h0,
    CFG_PULLUP = 2'h1,
    CFG_CAP    = 2'h2
  } wwd_cfg_e;

  typedef enum logic [3:0] {
    ST_UVLO    = 4'h0,
    ST_PROBE   = 4'h1,
    ST_BOOT    = 4'h2,
    ST_DIS     = 4'h3,
    ST_SETTLE  = 4'h4,
    ST_RECOVER = 4'h5,
    ST_FIRST   = 4'h6,
    ST_WINDOW  = 4'h7,
    ST_FAULT   = 4'h8
  } wwd_state_e;

  // Register bus
  localparam int             AW           = 8;
  localparam int             CNT_W        = 16;
  localparam int             STAT_PAD     = 21;
  localparam logic [AW-1:0]  OFS_STATUS   = 8'h00;
  localparam logic [AW-1:0]  OFS_FAULTS   = 8'h04;
  localparam logic [AW-1:0]  OFS_CTRL     = 8'h08;
  localparam int             CTRL_CLR_BIT = 0;
  localparam logic [1:0]     RESP_OKAY    = 2'h0;
  localparam logic [1:0]     RESP_SLVERR  = 2'h2;

endpackage

// ===== core/wwd_sync.sv
// Purpose: Three-flop input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to aclk
// Notes:   Output moves only when second and third stage agree
`timescale 1ns/1ps
module wwd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Raw and filtered levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // First stage feeds only the second stage
  assign q_nxt = (~(s2_r ^ s3_r) & s2_r) | ((s2_r ^ s3_r) & q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
    end
  end

endmodule

// ===== testbench/wwd_host_model.sv
// Purpose: Host processor model servicing the kick pin
// Assumes: One kick request at a time, requests ignored while busy
// Notes:   Falls after kick_dly cycles, rises again 4 cycles later
`timescale 1ns/1ps
module wwd_host_model (
  // Clock
  input  wire logic        aclk,
  // Request from bench
  input  wire logic        kick_req,
  input  wire logic [15:0] kick_dly,
  // Kick pin
  output logic             kick_input
);
  initial kick_input = 1'b1;
  always @(posedge aclk)
    if (kick_req)
    begin
      repeat (kick_dly) @(posedge aclk);
      kick_input <= 1'b0;
      repeat (4) @(posedge aclk);
      kick_input <= 1'b1; // Rising edge must leave timing alone
    end
endmodule

// ===== testbench/wwd_top_tb_top.sv
// Purpose: Self-checking bench for the window watchdog core
// Assumes: Reset delay pin pulled up then on a capacitor, window pin open, factory window timing
// Notes:   Shortened counts; window capacitor comparator held inactive, reset delay comparator modelled
`timescale 1ns/1ps
module wwd_top_tb_top;
  import wwd_pkg::*;
  localparam int TK = 2;
  localparam int SH = 10;
  logic        aclk = 1'b0, aresetn = 1'b0, supply_ok = 1'b0, sel0 = 1'b0, sel1 = 1'b0, kreq = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        kick, fo_n, wpd, rchg, awready, wready, bvalid, arready, rvalid;
  logic        rpin = 1'b1, rdone = 1'b0;
  logic [3:0]  wstrb = 4'hF;
  int          ccnt = 0;
  logic [15:0] kdly = 16'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          bad_count = 0, n_tests = 0, fcnt = 0, n, x;
  int          hold_cyc = (HOLD_PU_US >> SH) * TK, lo_cyc = (LO_OPEN_R18 >> SH) * TK, up_cyc = (UP_OPEN_R18 >> SH) * TK;

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  wwd_host_model host (.aclk(aclk), .kick_req(kreq), .kick_dly(kdly), .kick_input(kick));

  // Capacitor on the reset delay pin reaches threshold after a fixed charge time
  always @(posedge aclk)
  begin
    ccnt  <= rchg ? ccnt + 1 : 0;
    rdone <= rchg && ccnt >= 30;
  end

  // Open window pin reads low only while pulled down
  wwd_top #(.TICK_CYC(TK), .PROBE_US(8), .SETTLE_US(4), .TIME_SHIFT(SH)) dut (
    .aclk(aclk), .aresetn(aresetn), .supply_ok(supply_ok), .window_select_0(sel0), .window_select_1(sel1),
    .kick_input(kick), .fault_output_n(fo_n), .reset_delay_cfg_pin(rpin), .window_timeout_cfg_pin(~wpd),
    .rst_cfg_pulldown(), .wd_cfg_pulldown(wpd), .rst_cap_done(rdone), .wd_cap_done(1'b0),
    .rst_cap_charge(rchg), .wd_cap_charge(), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    bad_count++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] e);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (i == 50)
      tmo();
    q = rdata;
    e = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] e);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (i == 50)
      tmo();
    e = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_state(input logic [3:0] s);
    int i;
    for (i = 0; i < 300; i++)
    begin
      rd(OFS_STATUS, d, r);
      if (d[3:0] === s)
        break;
    end
    if (i == 300)
      tmo();
  endtask

  task automatic kick_go(input int dl);
    kdly <= 16'(dl);
    kreq <= 1'b1;
    @(posedge aclk);
    kreq <= 1'b0;
  endtask

  // Waits for a fault, kicks during it, checks its length
  task automatic fault_len();
    int i;
    n = 0;
    for (i = 0; i < 400 && fo_n !== 1'b0; i++)
      @(posedge aclk);
    while (fo_n === 1'b0 && n < 400)
    begin
      kreq <= (n == 4);
      @(posedge aclk);
      n++;
    end
    kreq <= 1'b0;
    fcnt++;
    chk(n >= hold_cyc && n <= hold_cyc + 6, 1);
  endtask

  initial
  begin
    void'($urandom(32'hB08145AB));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    supply_ok <= 1'b1;
    wait_state(4'h6);
    chk(d[10:4], 7'h41);
    x = $urandom_range(10, 40);
    kick_go(x);
    wait_state(4'h7);
    x = lo_cyc + 8 + $urandom_range(0, 20);
    kick_go(x);
    repeat (x + 6) @(posedge aclk);
    rd(OFS_STATUS, d, r);
    chk({d[10], d[3:0]}, 5'h17);
    kick_go(0);
    fault_len();
    sel1 <= 1'b1;
    repeat (20) @(posedge aclk);
    rd(OFS_STATUS, d, r);
    chk(d[9:8], 0);
    fault_len();
    rd(OFS_STATUS, d, r);
    chk(d[9:8], 2);
    sel0 <= 1'b1;
    repeat (20) @(posedge aclk); // Shortened select gap
    sel1 <= 1'b0;
    wait_state(4'h3);
    kick_go(0);
    repeat (up_cyc) @(posedge aclk);
    rd(OFS_FAULTS, d, r);
    chk({fo_n, d[15:0]}, {1'b1, 16'(fcnt)});
    sel0 <= 1'b0;
    kick_go(0);
    repeat (16) @(posedge aclk);
    rd(OFS_STATUS, d, r);
    chk(d[10:0], 11'h416);
    supply_ok <= 1'b0;
    wait_state(4'h0);
    chk(d[10], 1);
    supply_ok <= 1'b1;
    wait_state(4'h6);
    chk(d[10:4], 7'h41);
    // Clear bit sits in byte lane 0, so a write without it must not clear
    wstrb <= 4'hE;
    wr(OFS_CTRL, 32'h1, r);
    rd(OFS_FAULTS, d, r);
    chk(d[15:0], 16'(fcnt));
    wstrb <= 4'hF;
    wr(OFS_CTRL, 32'h1, r);
    rd(OFS_FAULTS, d, r);
    chk({d[15:0], r}, {16'h0, RESP_OKAY});
    wr(8'h0C, 32'h1, r);
    chk(r, RESP_SLVERR);
    rd(8'h0C, d, r);
    chk({d, r}, {32'h0, RESP_SLVERR});
    // Capacitor on the reset delay pin, watchdog disabled during a fault
    supply_ok <= 1'b0;
    rpin <= 1'b0;
    wait_state(4'h0);
    supply_ok <= 1'b1;
    wait_state(4'h6);
    chk(d[7:4], 4'h2);
    for (n = 0; n < 400 && fo_n !== 1'b0; n++)
      @(posedge aclk);
    chk(n < 400, 1);
    sel0 <= 1'b1;
    wait_state(4'h3);
    chk({fo_n, d[10]}, 2'h3);
    sel0 <= 1'b0;
    wait_state(4'h5);
    chk(d[10], 1);
    wait_state(4'h6);
    wrap_up();
  end
endmodule
